// *** include/opdec_pkg.sv ***
// Shared constants, types and helpers for the operand specifier decoder.
// Assumes a single core clock; all users import the whole package.
package opdec_pkg;

	// Mode nibble codes of a general specifier
	localparam logic [3:0] LIT_MODE_MAX   = 4'h3;
	localparam logic [3:0] MODE_INDEX     = 4'h4;
	localparam logic [3:0] MODE_REG       = 4'h5;
	localparam logic [3:0] MODE_REG_DEF   = 4'h6;
	localparam logic [3:0] MODE_AUTODEC   = 4'h7;
	localparam logic [3:0] MODE_AUTOINC   = 4'h8;
	localparam logic [3:0] MODE_AUTOINC_D = 4'h9;
	localparam logic [3:0] MODE_BDISP     = 4'hA;
	localparam logic [3:0] MODE_BDISP_D   = 4'hB;
	localparam logic [3:0] MODE_WDISP     = 4'hC;
	localparam logic [3:0] MODE_WDISP_D   = 4'hD;
	localparam logic [3:0] MODE_LDISP_D   = 4'hF;

	// Register numbers and limits
	localparam logic [3:0] REG_PC       = 4'hF;
	localparam logic [3:0] UNP_QUAD_MIN = 4'hC;  // Two-register operands run short here
	localparam logic [3:0] UNP_OCTA_MIN = 4'hA;  // Four-register operands run short here

	// Operand sizes as log2 of bytes
	localparam logic [2:0] LOG_BYTE = 3'h0;
	localparam logic [2:0] LOG_WORD = 3'h1;
	localparam logic [2:0] LOG_LONG = 3'h2;
	localparam logic [2:0] LOG_QUAD = 3'h3;
	localparam logic [2:0] LOG_OCTA = 3'h4;
	localparam logic [2:0] PTR_LOG  = LOG_LONG;  // Pointers are longwords

	// Access types of a specifier
	typedef enum logic [2:0] {
		ACC_R = 3'h0, ACC_M = 3'h1, ACC_W = 3'h2,
		ACC_A = 3'h3, ACC_V = 3'h4, ACC_B = 3'h5
	} acc_t;

	// Data types of an operand
	typedef enum logic [3:0] {
		DT_B = 4'h0, DT_W = 4'h1, DT_L = 4'h2, DT_Q = 4'h3, DT_O = 4'h4,
		DT_F = 4'h5, DT_D = 4'h6, DT_G = 4'h7, DT_H = 4'h8
	} dtyp_t;

	// Kind of operand handed downstream
	typedef enum logic [2:0] {
		OK_VALUE = 3'h0, OK_ADDR = 3'h1, OK_BRANCH = 3'h2, OK_FIELD = 3'h3
	} okind_t;

	// One specifier from fetch; ext is the raw extension, pc_next points past it
	typedef struct packed {
		logic [7:0]  spec;
		logic [7:0]  base;
		logic [31:0] ext;
		acc_t        acc;
		dtyp_t       dtyp;
		logic [31:0] pc_next;
		logic        last;
	} spec_req_t;

	// Evaluated operand
	typedef struct packed {
		logic        valid;
		okind_t      kind;
		logic        is_reg;
		logic [31:0] addr;
		logic [31:0] data;
	} opnd_t;

	// Register side effect
	typedef struct packed {
		logic        valid;
		logic [3:0]  idx;
		logic [31:0] value;
	} gpr_upd_t;

	// Memory read request
	typedef struct packed {
		logic        valid;
		logic [31:0] addr;
		logic [2:0]  size_log;
	} rd_req_t;

	// Saved destination
	typedef struct packed {
		logic        is_reg;
		logic [31:0] addr;
		logic [2:0]  size_log;
	} dest_t;

	// Result store request
	typedef struct packed {
		logic        valid;
		dest_t       dest;
		logic [31:0] data;
	} wr_req_t;

	// Size of a data type in log2 bytes
	function automatic logic [2:0] size_log(input dtyp_t d);
		case (d)
			DT_B:                   size_log = LOG_BYTE;
			DT_W:                   size_log = LOG_WORD;
			DT_Q, DT_D, DT_G:       size_log = LOG_QUAD;
			DT_O, DT_H:             size_log = LOG_OCTA;
			default:                size_log = LOG_LONG;
		endcase
	endfunction : size_log

endpackage : opdec_pkg

// *** hw/dest_ram.sv ***
// Small store for saved destinations, one write and one registered read port.
// Assumes the reader presents its address one cycle before it needs data.
`timescale 1ns/1ps
`default_nettype none
module dest_ram
	import opdec_pkg::*;
#(
	parameter int DEPTH = 8,
	parameter int AW    = 3
)
(
	// Clock
	input  wire logic          i_clk,
	// Write port
	input  wire logic          i_we,
	input  wire logic [AW-1:0] i_waddr,
	input  wire dest_t         i_wdata,
	// Read port
	input  wire logic [AW-1:0] i_raddr,
	output dest_t              o_rdata
);
	dest_t mem [DEPTH];  // Entry array

	// Write and registered read
	always_ff @(posedge i_clk)
	begin
		if (i_we)
			mem[i_waddr] <= i_wdata;
		o_rdata <= mem[i_raddr];
	end
endmodule : dest_ram
`default_nettype wire

// *** hw/addr_gen.sv ***
// Address arithmetic: index scaling and branch target.
// Assumes the caller has already chosen the base operand address.
`timescale 1ns/1ps
`default_nettype none
module addr_gen
	import opdec_pkg::*;
(
	// Index scaling
	input  wire logic [31:0] i_base,
	input  wire logic [31:0] i_rx,
	input  wire logic [2:0]  i_size_log,
	input  wire logic        i_index,
	// Branch displacement
	input  wire logic [31:0] i_pc,
	input  wire logic [15:0] i_disp,
	input  wire logic        i_disp_word,
	// Results
	output logic      [31:0] o_addr,
	output logic      [31:0] o_branch
);
	logic [31:0] scaled;  // Index times operand size
	logic [31:0] bdisp;   // Sign-extended branch displacement

	// Primary address is base, plus scaled index when indexed
	assign scaled = i_rx << i_size_log;
	assign o_addr = i_index ? i_base + scaled : i_base;

	// Byte or word displacement, width chosen by instruction
	assign bdisp    = i_disp_word ? {{16{i_disp[15]}}, i_disp}
	                              : {{24{i_disp[7]}}, i_disp[7:0]};
	assign o_branch = i_pc + bdisp;
endmodule : addr_gen
`default_nettype wire

// *** hw/operand_specifier_decoder.sv ***
// Operand specifier decoder and evaluation sequencer.
// Assumes fetch delivers whole specifiers with extensions and updated pc,
// and that execute owns the register file and supplies the results that this block stores.
// Contract
// - Split byte into mode and register nibbles
// - Literal for m, w, a, v faults
// - Multi-register operand near top is unpredictable
// - Index equals modified base: address unpredictable
// - PC modes: immediate, absolute, relative, deferred
// - Branch displacement byte or word, instruction-sized
// - Branch target is pc plus sign-extended displacement
// - Read, write, modify handled in stream order
// - Address saves address; branch saved, no memory
// - Execute, then store in specifier order
// - String operations may store early
// - Field operands form one implied operand
// - Multiple exceptions may report in any order
// - Autoincrement and autodecrement seen by later specifiers
// - All reads and addresses before any store
// - Modify read and write are not indivisible
// - Later same-address store remains in memory
// - Integer literal is zero-extended
// - Indexed address is base plus size times index
// - PC as index register faults
`timescale 1ns/1ps
`default_nettype none
module operand_specifier_decoder
	import opdec_pkg::*;
#(
	parameter int DEST_DEPTH = 8,
	parameter int DEST_AW    = 3
)
(
	// Clock and reset
	input  wire logic              i_clk,
	input  wire logic              i_rstn,
	// Specifier stream from fetch
	input  wire logic              i_spec_valid,
	input  wire spec_req_t         i_spec,
	output logic                   o_spec_ready,
	// Registers and side effects
	input  wire logic [15:0][31:0] i_gpr,
	output gpr_upd_t               o_gpr_upd,
	// Operands to execute
	output opnd_t                  o_opnd,
	output logic                   o_unpred,
	// Memory reads
	output rd_req_t                o_rd,
	input  wire logic              i_rd_ack,
	input  wire logic [31:0]       i_rd_data,
	// Execute handshake and results
	output logic                   o_exec_go,
	input  wire logic              i_exec_done,
	input  wire logic              i_exec_string,
	input  wire logic              i_res_valid,
	input  wire logic [31:0]       i_res_data,
	output logic                   o_res_ready,
	// Result stores
	output wr_req_t                o_wr,
	input  wire logic              i_wr_ack,
	// Faults
	output logic                   o_fault,
	output logic [2:0]             o_fault_cause
);
	// Sequencer states, Gray along the usual path
	typedef enum logic [2:0] {
		S_IDLE  = 3'b000, S_EVAL  = 3'b001, S_DEFER = 3'b011,
		S_OPRD  = 3'b010, S_EXEC  = 3'b110, S_STORE = 3'b111,
		S_FAULT = 3'b100
	} state_t;

	state_t               state_r, state_nxt;  // Sequencer state
	spec_req_t            spec_r;              // Specifier under evaluation
	logic [31:0]          addr_r;              // Address of pending read
	logic                 fwd_v_r;             // Bypass of last register update
	logic [DEST_AW-1:0]   dcnt_r, dcnt_nxt;    // Saved destinations
	logic [DEST_AW-1:0]   st_idx_r, st_idx_nxt; // Store pointer
	dest_t                dest_rd;             // Destination at store pointer
	gpr_upd_t             upd_nxt;             // Next register side effect
	opnd_t                opnd_nxt;            // Next operand
	rd_req_t              rd_nxt;              // Next read request
	wr_req_t              wr_nxt;              // Next store request

	// Field split of specifier and index base
	wire logic        idx_mode = spec_r.spec[7:4] == MODE_INDEX;
	wire logic [7:0]  bspec    = idx_mode ? spec_r.base : spec_r.spec;
	wire logic [3:0]  bm       = bspec[7:4];
	wire logic [3:0]  br       = bspec[3:0];
	wire logic [3:0]  rx       = spec_r.spec[3:0];
	wire acc_t        acc      = spec_r.acc;
	wire logic [2:0]  slog     = size_log(spec_r.dtyp);
	wire logic [31:0] sz32     = 32'h0000_0001 << slog;
	wire logic [31:0] ptr_sz   = 32'h0000_0001 << PTR_LOG;
	wire logic        is_pc    = br == REG_PC;

	// Register values, bypassing the update just issued
	wire logic [31:0] gpr_b  = (fwd_v_r && o_gpr_upd.idx == br) ? o_gpr_upd.value : i_gpr[br];
	wire logic [31:0] rxv    = (fwd_v_r && o_gpr_upd.idx == rx) ? o_gpr_upd.value : i_gpr[rx];
	wire logic [31:0] rv     = is_pc ? spec_r.pc_next : gpr_b;  // PC reads as updated pc

	// Mode classes
	wire logic is_lit   = bm <= LIT_MODE_MAX;
	wire logic reg_mode = bm == MODE_REG;
	wire logic is_brn   = acc == ACC_B;
	wire logic imm      = bm == MODE_AUTOINC && is_pc;
	wire logic absl     = bm == MODE_AUTOINC_D && is_pc;
	wire logic autox    = (bm == MODE_AUTODEC || bm == MODE_AUTOINC || bm == MODE_AUTOINC_D)
	                      && !is_pc;
	wire logic deferred = (bm == MODE_AUTOINC_D && !is_pc) || bm == MODE_BDISP_D
	                      || bm == MODE_WDISP_D || bm == MODE_LDISP_D;

	// Reserved-mode checks, raised at once whatever else is pending
	wire logic f_lit = is_lit && (acc != ACC_R || idx_mode);
	wire logic f_reg = reg_mode && (acc == ACC_A || idx_mode);
	wire logic f_idx = idx_mode && (bm == MODE_INDEX || rx == REG_PC);
	wire logic fault = !is_brn && (f_lit || f_reg || f_idx);

	// Unpredictable cases: short register run, or index on modified base
	wire logic unp_reg = reg_mode && ((slog == LOG_QUAD && br >= UNP_QUAD_MIN)
	                     || (slog == LOG_OCTA && br >= UNP_OCTA_MIN));
	wire logic unp_idx = idx_mode && autox && rx == br;

	// Displacement sign extension by mode
	wire logic        d_byte = bm == MODE_BDISP || bm == MODE_BDISP_D;
	wire logic        d_word = bm == MODE_WDISP || bm == MODE_WDISP_D;
	wire logic [31:0] disp   = d_byte ? {{24{spec_r.ext[7]}}, spec_r.ext[7:0]}
	                         : d_word ? {{16{spec_r.ext[15]}}, spec_r.ext[15:0]}
	                         : spec_r.ext;

	// Base operand address before deferral
	wire logic [31:0] a0 = (bm == MODE_AUTODEC) ? rv - sz32
	                     : absl ? spec_r.ext
	                     : imm ? spec_r.pc_next - sz32
	                     : (bm >= MODE_BDISP) ? rv + disp : rv;

	// Register side effect of autoincrement and autodecrement
	wire logic        upd_en  = (state_r == S_EVAL) && !fault && !is_brn && autox;
	wire logic [31:0] upd_val = (bm == MODE_AUTODEC) ? rv - sz32
	                          : (bm == MODE_AUTOINC_D) ? rv + ptr_sz : rv + sz32;

	// Value known without memory: literal, register or immediate
	wire logic        val_direct = is_lit || reg_mode || (imm && acc == ACC_R);
	wire logic [31:0] lit_val    = {26'h0, bspec[5:0]};  // Zero extension
	wire logic [31:0] dir_val    = is_lit ? lit_val : reg_mode ? rv : spec_r.ext;
	wire logic        needs_rd   = (acc == ACC_R || acc == ACC_M) && !val_direct;

	// Address arithmetic
	logic [31:0] eaddr;   // Final operand address
	logic [31:0] br_tgt;  // Branch target
	wire  logic [31:0] ea_base = (state_r == S_DEFER) ? i_rd_data : a0;

	addr_gen u_addr_gen (
		.i_base      (ea_base),
		.i_rx        (rxv),
		.i_size_log  (slog),              // Index scaled by operand size
		.i_index     (idx_mode),
		.i_pc        (spec_r.pc_next),
		.i_disp      (spec_r.ext[15:0]),
		.i_disp_word (spec_r.dtyp != DT_B), // Width fixed by instruction
		.o_addr      (eaddr),
		.o_branch    (br_tgt)
	);

	// Completion of one specifier
	wire logic ev_done = (state_r == S_EVAL) && !fault
	                     && (is_brn || val_direct || (!deferred && !needs_rd));
	wire logic df_ack  = (state_r == S_DEFER) && i_rd_ack;
	wire logic fin     = ev_done || (df_ack && !needs_rd) || ((state_r == S_OPRD) && i_rd_ack);
	wire logic go_rd   = ((state_r == S_EVAL) && !fault && !val_direct && !deferred && needs_rd)
	                     || (df_ack && needs_rd);
	wire logic save_dst = fin && (acc == ACC_W || acc == ACC_M);
	wire logic [31:0] fin_addr = (state_r == S_OPRD) ? addr_r
	                           : reg_mode ? {28'h0, br} : eaddr;

	// Store phase handshakes and specifier take
	wire logic res_take = o_res_ready && i_res_valid;
	wire logic wr_done  = o_wr.valid && i_wr_ack;
	wire logic st_last  = st_idx_r == dcnt_r - 1'b1;
	wire logic spec_take = (state_r == S_IDLE) && o_spec_ready && i_spec_valid;

	// Next state
	always_comb
	begin
		state_nxt = state_r;
		unique case (state_r)
			S_IDLE:  if (spec_take) state_nxt = S_EVAL;
			S_EVAL:
			begin
				if (fault)
					state_nxt = S_FAULT;
				else if (ev_done)
					state_nxt = spec_r.last ? S_EXEC : S_IDLE;
				else if (deferred)
					state_nxt = S_DEFER;
				else
					state_nxt = S_OPRD;
			end
			S_DEFER:
			begin
				if (i_rd_ack)
					state_nxt = needs_rd ? S_OPRD : (spec_r.last ? S_EXEC : S_IDLE);
			end
			S_OPRD:  if (i_rd_ack) state_nxt = spec_r.last ? S_EXEC : S_IDLE;
			S_EXEC:
			begin
				// String work has already stored its own results
				if (i_exec_done)
					state_nxt = (i_exec_string || dcnt_r == '0) ? S_IDLE : S_STORE;
			end
			S_STORE: if (wr_done && st_last) state_nxt = S_IDLE;
			S_FAULT: state_nxt = S_IDLE;
			default: state_nxt = S_IDLE;
		endcase
	end

	// Destination bookkeeping, stores walk saved order
	assign dcnt_nxt   = (state_nxt == S_IDLE && (state_r == S_EXEC || state_r == S_STORE
	                    || state_r == S_FAULT)) ? '0
	                  : save_dst ? dcnt_r + 1'b1 : dcnt_r;
	assign st_idx_nxt = (state_r == S_EXEC) ? '0
	                  : (wr_done && !st_last) ? st_idx_r + 1'b1 : st_idx_r;

	// Operand hand-off; address and field kinds carry address only, plus the register value in register mode
	always_comb
	begin
		opnd_nxt        = '0;
		opnd_nxt.valid  = fin;
		opnd_nxt.is_reg = reg_mode && !is_brn;
		opnd_nxt.addr   = fin_addr;
		unique case (acc)
			ACC_B:   opnd_nxt.kind = OK_BRANCH;
			ACC_V:   opnd_nxt.kind = OK_FIELD;
			ACC_A,
			ACC_W:   opnd_nxt.kind = OK_ADDR;
			default: opnd_nxt.kind = OK_VALUE;
		endcase
		if (is_brn)
			opnd_nxt.data = br_tgt;
		else if (state_r == S_OPRD)
			opnd_nxt.data = i_rd_data;
		else if (val_direct)
			opnd_nxt.data = dir_val;
		else
			opnd_nxt.data = '0;
	end

	// Read requests: pointer first, then operand; no lock is held
	always_comb
	begin
		rd_nxt = o_rd;
		if (i_rd_ack)
			rd_nxt.valid = 1'b0;
		if (state_r == S_EVAL && !fault && deferred && !is_brn && !val_direct)
			rd_nxt = '{valid: 1'b1, addr: a0, size_log: PTR_LOG};
		else if (go_rd)
			rd_nxt = '{valid: 1'b1, addr: eaddr, size_log: slog};
	end

	// Store requests, only after execute finished
	always_comb
	begin
		wr_nxt = o_wr;
		if (wr_done)
			wr_nxt.valid = 1'b0;
		if (res_take)
			wr_nxt = '{valid: 1'b1, dest: dest_rd, data: i_res_data};
	end

	// Index and value are held together so the bypass never pairs stale data with a new register
	assign upd_nxt = '{valid: upd_en, idx: upd_en ? br : o_gpr_upd.idx,
	                   value: upd_en ? upd_val : o_gpr_upd.value};

	// Destination entry written when a write or modify specifier completes
	wire dest_t dst_wdata = '{is_reg: reg_mode, addr: fin_addr, size_log: slog};

	// Saved destination store
	dest_ram #(
		.DEPTH (DEST_DEPTH),
		.AW    (DEST_AW)
	) u_dest_ram (
		.i_clk   (i_clk),
		.i_we    (save_dst),
		.i_waddr (dcnt_r),
		.i_wdata (dst_wdata),
		.i_raddr (st_idx_nxt),
		.o_rdata (dest_rd)
	);

	// Sequencer and counters
	always_ff @(posedge i_clk or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			state_r  <= S_IDLE;
			dcnt_r   <= '0;
			st_idx_r <= '0;
		end
		else
		begin
			state_r  <= state_nxt;
			dcnt_r   <= dcnt_nxt;
			st_idx_r <= st_idx_nxt;
		end
	end

	// Specifier capture and pending read address
	always_ff @(posedge i_clk or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			spec_r <= '0;
			addr_r <= '0;
		end
		else
		begin
			if (spec_take)
				spec_r <= i_spec;
			if (go_rd)
				addr_r <= eaddr;
		end
	end

	// Register side effects; bypass lives until execute takes over or a fault is raised
	always_ff @(posedge i_clk or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			o_gpr_upd <= '0;
			fwd_v_r   <= 1'b0;
		end
		else
		begin
			o_gpr_upd <= upd_nxt;
			if (state_nxt == S_EXEC || state_nxt == S_FAULT)
				fwd_v_r <= 1'b0;
			else if (upd_en)
				fwd_v_r <= 1'b1;
		end
	end

	// Operand, read, store and control outputs
	always_ff @(posedge i_clk or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			o_opnd        <= '0;
			o_unpred      <= 1'b0;
			o_rd          <= '0;
			o_wr          <= '0;
			o_spec_ready  <= 1'b0;
			o_exec_go     <= 1'b0;
			o_res_ready   <= 1'b0;
			o_fault       <= 1'b0;
			o_fault_cause <= '0;
		end
		else
		begin
			o_opnd        <= opnd_nxt;
			o_unpred      <= fin && (unp_reg || unp_idx);
			o_rd          <= rd_nxt;
			o_wr          <= wr_nxt;
			o_spec_ready  <= state_nxt == S_IDLE && !spec_take;
			o_exec_go     <= state_nxt == S_EXEC && state_r != S_EXEC;
			o_res_ready   <= state_nxt == S_STORE && !wr_nxt.valid;
			o_fault       <= state_r == S_EVAL && fault;
			o_fault_cause <= (state_r == S_EVAL) ? {f_idx, f_reg, f_lit} : 3'h0;
		end
	end

	// Checks
	AST_LIT_FAULT: assert property (@(posedge i_clk) disable iff (!i_rstn)
		state_r == S_EVAL && is_lit && !is_brn && acc != ACC_R |=> o_fault && o_fault_cause[0])
		else $error("literal with non-read access did not fault");
	AST_PC_INDEX: assert property (@(posedge i_clk) disable iff (!i_rstn)
		state_r == S_EVAL && idx_mode && rx == REG_PC && !is_brn |=> o_fault)
		else $error("pc as index register did not fault");
	AST_BRANCH: assert property (@(posedge i_clk) disable iff (!i_rstn)
		state_r == S_EVAL && is_brn |=> o_opnd.valid && o_opnd.kind == OK_BRANCH
		&& o_opnd.data == $past(br_tgt) && !o_rd.valid)
		else $error("branch target wrong or memory touched");
	AST_AUTOINC: assert property (@(posedge i_clk) disable iff (!i_rstn)
		upd_en && bm == MODE_AUTOINC |=> o_gpr_upd.valid
		&& o_gpr_upd.value == $past(rv) + $past(sz32))
		else $error("autoincrement value wrong");
	AST_FAULT_CLEAN: assert property (@(posedge i_clk) disable iff (!i_rstn)
		o_fault |-> !o_gpr_upd.valid && !o_wr.valid ##1 state_r == S_IDLE && dcnt_r == '0)
		else $error("fault left state changed");
	AST_STORE_PHASE: assert property (@(posedge i_clk) disable iff (!i_rstn)
		o_wr.valid |-> state_r == S_STORE)
		else $error("store issued outside store phase");
	AST_STORE_ORDER: assert property (@(posedge i_clk) disable iff (!i_rstn)
		state_r == S_STORE && wr_done && !st_last |=> st_idx_r == $past(st_idx_r) + 1'b1)
		else $error("stores out of order");
	AST_LITERAL: assert property (@(posedge i_clk) disable iff (!i_rstn)
		state_r == S_EVAL && is_lit && acc == ACC_R && !idx_mode |=> o_opnd.valid
		&& o_opnd.data == {26'h0, $past(bspec[5:0])})
		else $error("literal not zero-extended");
	AST_WRITE_NOREAD: assert property (@(posedge i_clk) disable iff (!i_rstn)
		state_r == S_EVAL && acc == ACC_W && !fault && !deferred |=> !o_rd.valid [*2])
		else $error("write specifier read memory");
	CVR_BRANCH: cover property (@(posedge i_clk) disable iff (!i_rstn)
		o_opnd.valid && o_opnd.kind == OK_BRANCH);
	CVR_DEFER: cover property (@(posedge i_clk) disable iff (!i_rstn)
		state_r == S_DEFER ##[1:20] state_r == S_OPRD);
	CVR_STORE: cover property (@(posedge i_clk) disable iff (!i_rstn) wr_done && st_last);
	CVR_FAULT: cover property (@(posedge i_clk) disable iff (!i_rstn) o_fault);
endmodule : operand_specifier_decoder
`default_nettype wire

// *** tb/opdec_far_side.sv ***
// Far-side model: memory answering reads and accepting result stores.
// Assumes the decoder holds each request until acknowledged.
`timescale 1ns/1ps
`default_nettype none
module opdec_far_side
	import opdec_pkg::*;
(
	// Clock and reset
	input  wire logic    i_clk,
	input  wire logic    i_rstn,
	// Requests from the decoder
	input  wire rd_req_t i_rd,
	input  wire wr_req_t i_wr,
	// Answers
	output logic         o_rd_ack,
	output logic [31:0]  o_rd_data,
	output logic         o_wr_ack
);
	int wait_r;  // Cycles left before the answer, one to four

	initial
	begin
		o_rd_ack = 0;
		o_wr_ack = 0;
		o_rd_data = 32'h0;
		wait_r = 0;
	end

	// Answers after a random wait; data toggles while no answer stands
	always @(posedge i_clk)
	begin
		#2;
		o_rd_ack = 0;
		o_wr_ack = 0;
		o_rd_data = ~o_rd_data;
		if (i_rstn && (i_rd.valid || i_wr.valid))
		begin
			if (wait_r == 0)
				wait_r = 1 + $urandom % 4;
			wait_r--;
			if (wait_r == 0)
			begin
				o_rd_ack = i_rd.valid;
				o_wr_ack = !i_rd.valid;
				o_rd_data = i_rd.addr ^ 32'h5A5A_0000;
			end
		end
	end
endmodule : opdec_far_side
`default_nettype wire

// *** tb/operand_specifier_decoder_tb.sv ***
// Self-checking bench for the operand specifier decoder.
// Assumes the far-side model serves memory reads and stores.
`timescale 1ns/1ps
`default_nettype none
module operand_specifier_decoder_tb
	import opdec_pkg::*;
;
	logic i_clk, i_rstn, i_spec_valid, i_rd_ack, i_wr_ack, o_spec_ready, o_unpred;
	logic i_exec_done, i_exec_string, i_res_valid, o_exec_go, o_res_ready, o_fault, flt, unp;
	logic [31:0] i_rd_data, i_res_data, a;
	logic [15:0][31:0] i_gpr;
	logic [2:0] o_fault_cause, cause;
	spec_req_t i_spec;
	gpr_upd_t o_gpr_upd, up;
	opnd_t o_opnd, op;
	rd_req_t o_rd;
	wr_req_t o_wr;
	int error_cnt, samples_checked, cyc, x;
	logic [31:0] dq[$];  // Model of saved destinations, in stream order

	operand_specifier_decoder DUT (.i_clk, .i_rstn, .i_spec_valid, .i_spec, .o_spec_ready,
		.i_gpr, .o_gpr_upd, .o_opnd, .o_unpred, .o_rd, .i_rd_ack, .i_rd_data, .o_exec_go,
		.i_exec_done, .i_exec_string, .i_res_valid, .i_res_data, .o_res_ready, .o_wr,
		.i_wr_ack, .o_fault, .o_fault_cause);
	opdec_far_side far (.i_clk, .i_rstn, .i_rd(o_rd), .i_wr(o_wr), .o_rd_ack(i_rd_ack),
		.o_rd_data(i_rd_data), .o_wr_ack(i_wr_ack));

	// Clock, 25 ns period
	initial
	begin
		i_clk = 0;
		forever #12.5 i_clk = ~i_clk;
	end

	// Hang guard
	always @(posedge i_clk)
	begin
		cyc++;
		if (cyc == 5000)
		begin
			error_cnt++;
			$display("mismatch %0t timeout", $time);
			test_done();
		end
	end

	task automatic test_done;
		$display("checks %0d mismatches %0d", samples_checked, error_cnt);
		if (error_cnt == 0 && samples_checked > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : test_done

	task automatic check(input logic ok, input string m);
		samples_checked++;
		if (ok !== 1'b1)
		begin
			error_cnt++;
			$display("mismatch %0t %s", $time, m);
		end
	endtask : check

	task automatic step;
		@(posedge i_clk);
		#2;
	endtask : step

	// One specifier: offer, wait for take, then collect operand or fault
	task automatic xfer(input logic [7:0] s, b, input acc_t ac, input dtyp_t d,
		input logic [31:0] e, pc, input logic l);
		int n;
		i_spec = '{s, b, e, ac, d, pc, l};
		i_spec_valid = 1;
		for (n = 0; n < 50 && o_spec_ready !== 1'b1; n++) step();
		step();
		i_spec_valid = 0;
		up = '0;
		flt = 0;
		op = '0;
		for (n = 0; n < 50 && !flt && !op.valid; n++)
		begin
			check(o_wr.valid === 1'b0, "store during evaluation");
			if (o_gpr_upd.valid === 1'b1)
				up = o_gpr_upd;
			flt = o_fault;
			op = o_opnd;
			unp = o_unpred;
			cause = o_fault_cause;
			if (!flt && !op.valid)
				step();
		end
	endtask : xfer

	// Execute handshake and result stores, checked against the queue
	task automatic run_exec(input logic str);
		int n;
		for (n = 0; n < 20 && o_exec_go !== 1'b1; n++) step();
		check(o_exec_go === 1'b1, "execute start");
		i_exec_done = 1;
		i_exec_string = str;
		step();
		i_exec_done = 0;
		if (str)
			dq = {};  // String work has stored its own results
		while (dq.size() > 0)
		begin
			for (n = 0; n < 20 && o_res_ready !== 1'b1; n++) step();
			i_res_valid = 1;
			i_res_data = $urandom;
			a = i_res_data;
			step();
			i_res_valid = 0;
			for (n = 0; n < 20 && o_wr.valid !== 1'b1; n++) step();
			check(o_wr.data === a && o_wr.dest.addr === dq.pop_front(), "store");
			for (n = 0; n < 20 && o_wr.valid === 1'b1; n++) step();
		end
		for (n = 0; n < 20 && o_spec_ready !== 1'b1; n++) step();
		check(o_spec_ready === 1'b1 && o_wr.valid === 1'b0, "idle");
	endtask : run_exec

	initial
	begin
		i_rstn = 0;
		i_spec_valid = 0;
		i_spec = '0;
		i_exec_done = 0;
		i_exec_string = 0;
		i_res_valid = 0;
		i_res_data = 32'h0;
		error_cnt = 0;
		samples_checked = 0;
		cyc = 0;
		x = $urandom(32'hC8D0);
		for (x = 0; x < 16; x++) i_gpr[x] = $urandom;
		repeat (12) @(posedge i_clk);
		#2 i_rstn = 1;
		// Literal for every access type except branch
		for (x = 0; x < 5; x++)
		begin
			a = $urandom % 64;
			xfer({2'b00, a[5:0]}, 8'h00, acc_t'(x), DT_L, 0, 0, 0);
			check(x == 0 ? op.data === a : (flt & cause[0]) === 1'b1, "literal");
		end
		// Register mode, then register runs near the top
		xfer(8'h53, 0, ACC_R, DT_L, 0, 0, 0);
		check(op.is_reg === 1'b1 && op.addr === 32'h3, "register");
		xfer(8'h53, 0, ACC_A, DT_L, 0, 0, 0);
		check((flt & cause[1]) === 1'b1, "register address");
		for (x = 0; x < 4; x++)
		begin
			xfer(8'h5C - x, 0, ACC_R, x[1] ? DT_O : DT_Q, 0, 0, 0);
			check(unp === (x[0] ? 1'b0 : 1'b1), "short register run");
		end
		xfer(8'h4F, 8'h63, ACC_R, DT_L, 0, 0, 0);
		check((flt & cause[2]) === 1'b1, "pc index");
		// Index scaling over all sizes
		for (x = 0; x < 5; x++)
		begin
			xfer(8'h42, 8'h67, ACC_A, dtyp_t'(x), 0, 0, 0);
			check(op.addr === i_gpr[7] + (i_gpr[2] << x), "indexed");
		end
		xfer(8'h49, 8'h89, ACC_A, DT_L, 0, 0, 0);
		check(unp === 1'b1, "index on modified base");
		// Branch displacements, byte then word
		for (x = 0; x < 2; x++)
		begin
			a = $urandom;
			xfer(a[7:0], 0, ACC_B, dtyp_t'(x), {16'h0, a[15:0]}, i_gpr[0], 0);
			check(op.kind === OK_BRANCH && op.data === i_gpr[0] + (x ? {{16{a[15]}}, a[15:0]}
				: {{24{a[7]}}, a[7:0]}), "branch");
		end
		// Autoincrement seen by the next specifier, which reads memory
		xfer(8'h8A, 0, ACC_A, DT_L, 0, 0, 0);
		check(up.value === i_gpr[10] + 4 && op.addr === i_gpr[10], "autoincrement");
		xfer(8'h8A, 0, ACC_R, DT_L, 0, 0, 0);
		check(op.data === ((i_gpr[10] + 4) ^ 32'h5A5A_0000), "read");
		xfer(8'h75, 0, ACC_A, DT_W, 0, 0, 0);
		check(op.addr === i_gpr[5] - 2 && up.value === i_gpr[5] - 2, "autodecrement");
		// Byte relative deferred: pointer read, then operand read
		a = $urandom;
		xfer(8'hBF, 0, ACC_R, DT_L, {24'h0, a[7:0]}, a, 0);
		check(op.data === a + {{24{a[7]}}, a[7:0]}, "relative deferred");
		// Two writes to one address, then a string instruction
		xfer(8'h63, 0, ACC_W, DT_L, 0, 0, 0);
		check(op.kind === OK_ADDR && op.addr === i_gpr[3], "write address");
		xfer(8'h63, 0, ACC_W, DT_L, 0, 0, 1);
		dq = {i_gpr[3], i_gpr[3]};
		run_exec(0);
		xfer(8'h63, 0, ACC_W, DT_L, 0, 0, 1);
		run_exec(1);
		test_done();
	end
endmodule : operand_specifier_decoder_tb
`default_nettype wire
